// ---- fpwm_duty_map.sv ----
`include "fpwm_map.svh"
`default_nettype none
// ***********************************************
// step to compare count
// ***********************************************
module fpwm_duty_map
    import fpwm_pkg::*;
(
    input wire logic [3:0] step_i,
    input wire logic hf_map_i,
    input wire logic [21:0] period_i,
    output logic [21:0] compare_o
);
    logic [6:0] num; // duty as numerator over the common denominator
    logic [28:0] prod; // wide enough for the slowest period
    logic [28:0] quot;

    // numerator lookup: exact fractions keep every step within one count
    always_comb begin
        num = 7'h00;
        if (step_i == 4'h0) begin
            num = 7'h00; // off
        end else if (step_i >= 4'(`FPWM_STEP_MAX)) begin
            num = 7'(`FPWM_DUTY_DEN); // 100 percent
        end else if (hf_map_i) begin
            num = 7'((step_i + `FPWM_HF_OFS) * `FPWM_HF_MUL); // 25 percent + 6.25 per step
        end else if (step_i == 4'hB) begin
            num = 7'(`FPWM_LF_NUM_11);
        end else if (step_i == 4'hC) begin
            num = 7'(`FPWM_LF_NUM_12);
        end else begin
            num = 7'((step_i + `FPWM_LF_OFS) * `FPWM_LF_MUL); // 25 to 57.14 percent
        end
        prod = 29'(period_i) * 29'(num);
        quot = prod / 29'(`FPWM_DUTY_DEN); // floor keeps error below one count
        compare_o = quot[21:0];
    end
endmodule
`default_nettype wire

// ---- fpwm_fan_load.sv ----
`default_nettype none
module fpwm_fan_load (
    input wire logic clock_i,
    input wire logic pwm_i,
    output var int period_o,
    output var int high_o,
    output var int rises_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt; // cycles since last rising edge
    int hi; // high cycles since last rising edge
    logic last; // drive level one cycle ago
    initial begin
        period_o = 0;
        high_o = 0;
        rises_o = 0;
        cnt = 0;
        hi = 0;
        last = 1'b0;
    end
    // fan stage sees only edges; a 100 percent drive never rises, so no new figure
    always @(posedge clock_i) begin
        if (pwm_i && !last) begin
            period_o <= cnt;
            high_o <= hi;
            rises_o <= rises_o + 1;
            cnt = 1;
            hi = 1;
        end else begin
            cnt = cnt + 1;
            hi = hi + (pwm_i ? 1 : 0);
        end
        last <= pwm_i;
    end
endmodule
`default_nettype wire

// ---- fpwm_map.svh ----
`ifndef FPWM_MAP_SVH
`define FPWM_MAP_SVH

// ***********************************************
// register offsets
// ***********************************************
`define FPWM_OFS_SPIN_CFG 8'hCA
`define FPWM_OFS_FREQ_MAP 8'hCB
`define FPWM_OFS_DUTY_REQ 8'hD0
`define FPWM_OFS_STATUS 8'hD1

// ***********************************************
// field positions and reset values
// ***********************************************
`define FPWM_FREQ_LSB 0
`define FPWM_FREQ_MSB 2
`define FPWM_HF_MAP_BIT 3
`define FPWM_SPIN_UP_DUTY_CODE_LSB 0
`define FPWM_SPIN_UP_DUTY_CODE_MSB 3
`define FPWM_SPIN_UP_DURATION_CODE_TOP_BIT 4
`define FPWM_SPIN_UP_DURATION_CODE_LSB 5
`define FPWM_SPIN_UP_DURATION_CODE_MSB 7
`define FPWM_RESET_BYTE 8'h00
`define FPWM_WRITABLE_FREQ_MAP 8'h0F

// ***********************************************
// timing
// ***********************************************
`define FPWM_CLK_HZ 40000000
`define FPWM_HZ_0 22500
`define FPWM_HZ_1 96
`define FPWM_HZ_2 84
`define FPWM_HZ_3 72
`define FPWM_HZ_4 60
`define FPWM_HZ_5 48
`define FPWM_HZ_6 36
`define FPWM_HZ_7 12
`define FPWM_MS_PER_S 1000
// spin-up lengths in milliseconds, low and high halves of the code
`define FPWM_SU_MS_L1 100
`define FPWM_SU_MS_L2 250
`define FPWM_SU_MS_L3 400
`define FPWM_SU_MS_L4 700
`define FPWM_SU_MS_L5 1000
`define FPWM_SU_MS_L6 2000
`define FPWM_SU_MS_L7 4000
`define FPWM_SU_MS_H_BASE 6000
`define FPWM_SU_MS_H_STEP 2000

// ***********************************************
// duty map fractions over a common denominator
// ***********************************************
`define FPWM_DUTY_DEN 112
`define FPWM_HF_OFS 3
`define FPWM_HF_MUL 7
`define FPWM_LF_OFS 6
`define FPWM_LF_MUL 4
`define FPWM_LF_NUM_11 80
`define FPWM_LF_NUM_12 96
`define FPWM_STEP_MAX 13

`endif

// ---- fpwm_pkg.sv ----
`default_nettype none
package fpwm_pkg;
    // register port request, one cycle per strobe
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fpwm_bus_req_t;
    // spin-up phase tracking
    typedef enum logic [0:0] {
        FPWM_RUN = 1'b0,
        FPWM_SPIN = 1'b1
    } fpwm_spin_state_t;
endpackage
`default_nettype wire

// ---- fpwm_top.sv ----
// Function
// - duration code is bit4 over bits7..5; zero disables
// - bits 2..0 select output frequency
// - codes give 22500,96,84,72,60,48,36,12 Hz
// - map bit only counts at 22.5 kHz
// - selected map governs every duty source
// - high map: 25 percent plus 6.25 steps
// - low map: 25..57.14, then 71.43,85.71,100
// - upper four bits reserved, read zero
// - duty zero to nonzero starts spin-up
// - spin-up duty code zero suppresses spin-up
`include "fpwm_map.svh"
`default_nettype none
module fpwm_top
    import fpwm_pkg::*;
#(
    // slow periods follow the millisecond timebase, so one override shortens them all
    parameter int unsigned MS_CYCLES = `FPWM_CLK_HZ / `FPWM_MS_PER_S,
    parameter int unsigned PERIOD_1 = MS_CYCLES * `FPWM_MS_PER_S / `FPWM_HZ_1,
    parameter int unsigned PERIOD_2 = MS_CYCLES * `FPWM_MS_PER_S / `FPWM_HZ_2,
    parameter int unsigned PERIOD_3 = MS_CYCLES * `FPWM_MS_PER_S / `FPWM_HZ_3,
    parameter int unsigned PERIOD_4 = MS_CYCLES * `FPWM_MS_PER_S / `FPWM_HZ_4,
    parameter int unsigned PERIOD_5 = MS_CYCLES * `FPWM_MS_PER_S / `FPWM_HZ_5,
    parameter int unsigned PERIOD_6 = MS_CYCLES * `FPWM_MS_PER_S / `FPWM_HZ_6,
    parameter int unsigned PERIOD_7 = MS_CYCLES * `FPWM_MS_PER_S / `FPWM_HZ_7
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire fpwm_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    output logic pwm_o,
    output logic spin_active_o
);
    // ***********************************************
    // lookup functions
    // ***********************************************

    // frequency code to period in cycles
    function automatic logic [21:0] period_of(input logic [2:0] code);
        logic [21:0] p;
        p = 22'(`FPWM_CLK_HZ / `FPWM_HZ_0);
        case (code)
            3'h0: p = 22'(`FPWM_CLK_HZ / `FPWM_HZ_0);
            3'h1: p = 22'(PERIOD_1);
            3'h2: p = 22'(PERIOD_2);
            3'h3: p = 22'(PERIOD_3);
            3'h4: p = 22'(PERIOD_4);
            3'h5: p = 22'(PERIOD_5);
            3'h6: p = 22'(PERIOD_6);
            3'h7: p = 22'(PERIOD_7);
            default: p = 22'(`FPWM_CLK_HZ / `FPWM_HZ_0);
        endcase
        return p;
    endfunction

    // duration code to milliseconds, zero means disabled
    function automatic logic [14:0] spin_ms_of(input logic top, input logic [2:0] low);
        logic [14:0] ms;
        ms = 15'h0000;
        if (top) begin
            ms = 15'(`FPWM_SU_MS_H_BASE + low * `FPWM_SU_MS_H_STEP);
        end else begin
            case (low)
                3'h1: ms = 15'(`FPWM_SU_MS_L1);
                3'h2: ms = 15'(`FPWM_SU_MS_L2);
                3'h3: ms = 15'(`FPWM_SU_MS_L3);
                3'h4: ms = 15'(`FPWM_SU_MS_L4);
                3'h5: ms = 15'(`FPWM_SU_MS_L5);
                3'h6: ms = 15'(`FPWM_SU_MS_L6);
                3'h7: ms = 15'(`FPWM_SU_MS_L7);
                default: ms = 15'h0000; // all zero: no spin-up
            endcase
        end
        return ms;
    endfunction

    // ***********************************************
    // register file
    // ***********************************************
    logic [7:0] spin_cfg; // duration code and spin-up duty code
    logic [3:0] freq_map; // map bit and frequency select
    logic [3:0] duty_req; // requested step written to the duty request register
    logic [7:0] next_spin_cfg;
    logic [3:0] next_freq_map;
    logic [3:0] next_duty_req;
    logic [7:0] next_rdata;
    logic duty_rise; // duty request leaves zero
    logic [2:0] pwm_frequency_select;
    logic high_freq_duty_map_select;
    logic [3:0] spin_up_duration_code;
    logic [3:0] spin_up_duty_code;
    logic [7:0] status_byte;

    assign pwm_frequency_select = freq_map[`FPWM_FREQ_MSB:`FPWM_FREQ_LSB];
    assign high_freq_duty_map_select = freq_map[`FPWM_HF_MAP_BIT];
    assign spin_up_duration_code = {spin_cfg[`FPWM_SPIN_UP_DURATION_CODE_TOP_BIT],
                                    spin_cfg[`FPWM_SPIN_UP_DURATION_CODE_MSB:`FPWM_SPIN_UP_DURATION_CODE_LSB]};
    assign spin_up_duty_code = spin_cfg[`FPWM_SPIN_UP_DUTY_CODE_MSB:`FPWM_SPIN_UP_DUTY_CODE_LSB];

    // writes, read mux and duty edge detect
    always_comb begin
        next_spin_cfg = spin_cfg;
        next_freq_map = freq_map;
        next_duty_req = duty_req;
        next_rdata = 8'h00; // read data stands one cycle only
        if (bus_i.wr) begin
            case (bus_i.addr)
                `FPWM_OFS_SPIN_CFG: next_spin_cfg = bus_i.wdata;
                // reserved upper nibble never stored
                `FPWM_OFS_FREQ_MAP: next_freq_map = 4'(bus_i.wdata & `FPWM_WRITABLE_FREQ_MAP);
                `FPWM_OFS_DUTY_REQ: next_duty_req = bus_i.wdata[3:0];
                default: next_freq_map = freq_map; // unmapped or read-only: ignored
            endcase
        end
        if (bus_i.rd) begin
            case (bus_i.addr)
                `FPWM_OFS_SPIN_CFG: next_rdata = spin_cfg;
                `FPWM_OFS_FREQ_MAP: next_rdata = {4'h0, freq_map};
                `FPWM_OFS_DUTY_REQ: next_rdata = {4'h0, duty_req};
                `FPWM_OFS_STATUS: next_rdata = status_byte;
                default: next_rdata = 8'h00; // unmapped reads zero
            endcase
        end
        duty_rise = (duty_req == 4'h0) && (next_duty_req != 4'h0);
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            spin_cfg <= `FPWM_RESET_BYTE;
            freq_map <= 4'h0;
            duty_req <= 4'h0;
            rdata_o <= 8'h00;
        end else begin
            spin_cfg <= next_spin_cfg;
            freq_map <= next_freq_map;
            duty_req <= next_duty_req;
            rdata_o <= next_rdata;
        end
    end

    // ***********************************************
    // spin-up timer
    // ***********************************************
    fpwm_spin_state_t spin_state;
    fpwm_spin_state_t next_spin_state;
    logic [15:0] ms_div; // millisecond prescaler off the fixed clock
    logic [14:0] ms_left; // milliseconds remaining
    logic [15:0] next_ms_div;
    logic [14:0] next_ms_left;
    logic [14:0] spin_ms;

    assign spin_ms = spin_ms_of(spin_up_duration_code[3], spin_up_duration_code[2:0]);

    // start on duty rise; abort if duty drops back to zero
    always_comb begin
        next_spin_state = spin_state;
        next_ms_div = ms_div;
        next_ms_left = ms_left;
        case (spin_state)
            FPWM_RUN: begin
                // no phase when duration or duty code is zero
                if (duty_rise && spin_ms != 15'h0000 && spin_up_duty_code != 4'h0) begin
                    next_spin_state = FPWM_SPIN;
                    next_ms_left = spin_ms;
                    next_ms_div = 16'h0000;
                end
            end
            FPWM_SPIN: begin
                if (duty_req == 4'h0) begin
                    next_spin_state = FPWM_RUN; // request withdrawn
                end else if (ms_div == 16'(MS_CYCLES - 1)) begin
                    next_ms_div = 16'h0000;
                    next_ms_left = ms_left - 15'h0001;
                    if (ms_left == 15'h0001) begin
                        next_spin_state = FPWM_RUN;
                    end
                end else begin
                    next_ms_div = ms_div + 16'h0001;
                end
            end
            default: next_spin_state = FPWM_RUN;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            spin_state <= FPWM_RUN;
            ms_div <= 16'h0000;
            ms_left <= 15'h0000;
            spin_active_o <= 1'b0;
        end else begin
            spin_state <= next_spin_state;
            ms_div <= next_ms_div;
            ms_left <= next_ms_left;
            spin_active_o <= (next_spin_state == FPWM_SPIN);
        end
    end

    // ***********************************************
    // period counter and output
    // ***********************************************
    logic [21:0] period; // period in use, latched at the boundary
    logic [21:0] compare; // high time in use
    logic [21:0] count;
    logic [21:0] next_period;
    logic [21:0] next_compare;
    logic [21:0] next_count;
    logic next_pwm;
    logic [3:0] eff_step; // step after spin-up override
    logic map_hf; // high map in force
    logic [21:0] new_period;
    logic [21:0] new_compare;
    logic [3:0] applied_step;
    logic [3:0] next_applied_step;

    assign new_period = period_of(pwm_frequency_select);
    // map bit only honoured at the top frequency
    assign map_hf = high_freq_duty_map_select && (pwm_frequency_select == 3'h0);
    // every source arrives as one step, so one map covers them all
    assign eff_step = (spin_state == FPWM_SPIN) ? spin_up_duty_code : duty_req;

    fpwm_duty_map u_map (
        .step_i(eff_step),
        .hf_map_i(map_hf),
        .period_i(new_period),
        .compare_o(new_compare)
    );

    assign status_byte = {spin_state == FPWM_SPIN, map_hf, 2'b00, applied_step};

    // new settings only at the period end, so no runt pulse reaches the fan
    always_comb begin
        next_period = period;
        next_compare = compare;
        next_applied_step = applied_step;
        next_count = count + 22'h000001;
        if (count >= period - 22'h000001) begin
            next_count = 22'h000000;
            next_period = new_period;
            next_compare = new_compare;
            next_applied_step = eff_step;
        end
        next_pwm = (next_count < next_compare);
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            period <= 22'(`FPWM_CLK_HZ / `FPWM_HZ_0);
            compare <= 22'h000000;
            count <= 22'h000000;
            applied_step <= 4'h0;
            pwm_o <= 1'b0;
        end else begin
            period <= next_period;
            compare <= next_compare;
            count <= next_count;
            applied_step <= next_applied_step;
            pwm_o <= next_pwm;
        end
    end
endmodule
`default_nettype wire

// ---- fpwm_top_asserts.sv ----
`default_nettype none
module fpwm_chk
    import fpwm_pkg::*;
#(
    parameter int unsigned MS_CYCLES = 40000
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire fpwm_bus_req_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic pwm_o,
    input wire logic spin_active_o
);
    // ********
    // helper state
    // ********
    localparam int unsigned SPIN_MAX = 20000 * MS_CYCLES + 2; // longest spin-up plus slack
    logic [7:0] spin_cfg; // last spin config byte written
    logic [31:0] spin_len; // cycles spent in the running spin-up
    logic [7:0] next_spin_cfg;
    logic [31:0] next_spin_len;
    // shadow of the spin config, and a run-length counter
    always_comb begin
        next_spin_cfg = spin_cfg;
        if (bus_i.wr && bus_i.addr == 8'hCA) begin
            next_spin_cfg = bus_i.wdata;
        end
        next_spin_len = spin_active_o ? spin_len + 32'h1 : 32'h0;
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            spin_cfg <= 8'h00;
            spin_len <= 32'h0;
        end else begin
            spin_cfg <= next_spin_cfg;
            spin_len <= next_spin_len;
        end
    end
    // ********
    // properties
    // ********
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    sequence rd_at(a);
        bus_i.rd && bus_i.addr == a;
    endsequence
    sequence wr_freq;
        bus_i.wr && bus_i.addr == 8'hCB;
    endsequence
    a_idle_read_zero: assert property (!bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_freq_readback: assert property (wr_freq ##1 rd_at(8'hCB) |=>
        rdata_o == ($past(bus_i.wdata, 2) & 8'h0F)) else $error("frequency byte lost");
    a_reserved_zero: assert property (rd_at(8'hCB) |=> rdata_o[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    a_unmapped_zero: assert property (bus_i.rd && !(bus_i.addr inside
        {8'hCA, 8'hCB, 8'hD0, 8'hD1}) |=> rdata_o == 8'h00) else $error("unmapped read");
    a_spin_cause: assert property ($rose(spin_active_o) |-> $past(bus_i.wr) &&
        $past(bus_i.addr) == 8'hD0 && $past(bus_i.wdata) != 8'h00) else $error("spin cause");
    a_spin_duty_gate: assert property ($rose(spin_active_o) |-> spin_cfg[3:0] != 4'h0)
        else $error("spin-up with zero spin duty");
    a_spin_dur_gate: assert property ($rose(spin_active_o) |-> spin_cfg[7:4] != 4'h0)
        else $error("spin-up with zero duration");
    a_spin_abort: assert property (spin_active_o && bus_i.wr && bus_i.addr == 8'hD0 &&
        bus_i.wdata == 8'h00 |-> ##[1:2] !spin_active_o) else $error("spin not aborted");
    a_spin_bound: assert property (spin_len <= SPIN_MAX)
        else $error("spin-up too long");
endmodule
bind fpwm_top fpwm_chk #(.MS_CYCLES(MS_CYCLES)) u_fpwm_chk (.clock_i(clock_i),
    .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o), .pwm_o(pwm_o),
    .spin_active_o(spin_active_o));
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fpwm_pkg::*;
    // ********
    // bench state
    // ********
    // periods at one cycle per millisecond: 1000 / Hz for the slow codes
    localparam int P [8] = '{1777, 10, 11, 13, 16, 20, 27, 83};
    localparam int SU_CODE [4] = '{1, 7, 8, 9}; // spin duration codes
    localparam int SU_MS [4] = '{100, 4000, 6000, 8000}; // their lengths in ms
    localparam int STEPS [5] = '{1, 5, 10, 11, 12}; // duty steps probed
    logic clock_i;
    logic resetn_i;
    fpwm_bus_req_t bus_i;
    logic [7:0] rdata_o;
    logic pwm_o;
    logic spin_active_o;
    int period, high, rises, miscompares, tests_run, n, num;
    logic [7:0] d;
    fpwm_top #(.MS_CYCLES(1)) u_fpwm_top (
        .clock_i(clock_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .pwm_o(pwm_o), .spin_active_o(spin_active_o));
    fpwm_fan_load u_fpwm_fan_load (.clock_i(clock_i), .pwm_i(pwm_o), .period_o(period),
        .high_o(high), .rises_o(rises));
    always #12.5 clock_i = ~clock_i;
    // ********
    // tasks
    // ********
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus_i.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus_i.rd <= 1'b0;
        @(negedge clock_i);
        v = rdata_o;
    endtask
    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus_i.rd <= 1'b0;
        @(negedge clock_i);
        q = rdata_o;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // wait for k fresh rises; the first may still close an old period
    task automatic settle(input int k);
        int s;
        int i;
        s = rises;
        for (i = 0; i < 20000 && rises < s + k; i++) @(posedge clock_i);
        if (rises < s + k) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic pwm_chk(input int f, input int nm);
        settle(3);
        check("period", period, P[f]);
        check("high time", high, P[f] * nm / 112);
    endtask
    // ********
    // sequence
    // ********
    initial begin
        clock_i = 1'b0;
        resetn_i = 1'b0;
        bus_i = '0;
        miscompares = 0;
        tests_run = 0;
        repeat (5) @(posedge clock_i);
        resetn_i <= 1'b1;
        rd(8'hCA, d);
        check("spin cfg reset", d, 8'h00);
        rd(8'hCB, d);
        check("freq reset", d, 8'h00);
        wr_rd(8'hCB, 8'hFF, d);
        check("reserved bits", d, 8'h0F);
        rd(8'h55, d);
        check("unmapped", d, 8'h00);
        // map bit set everywhere: only the fast rate may honour it
        wr(8'hD0, 8'h0B);
        for (int f = 0; f < 8; f++) begin
            wr(8'hCB, {5'h01, f[2:0]});
            pwm_chk(f, (f == 0) ? 98 : 80);
        end
        for (int m = 0; m < 2; m++) begin
            wr(8'hCB, {4'h0, m[0], 3'h0});
            foreach (STEPS[i]) begin
                wr(8'hD0, STEPS[i][7:0]);
                num = (STEPS[i] <= 10) ? (6 + STEPS[i]) * 4 : (STEPS[i] == 11 ? 80 : 96);
                pwm_chk(0, m ? (3 + STEPS[i]) * 7 : num);
            end
        end
        // fast rate, map bit set, step 12 applied, no spin-up
        rd(8'hD1, d);
        check("status", d, 8'h4C);
        // spin-up lengths at one cycle per millisecond
        foreach (SU_CODE[i]) begin
            wr(8'hD0, 8'h00);
            wr(8'hCA, {SU_CODE[i][2:0], SU_CODE[i][3], 4'h5});
            wr(8'hD0, 8'h03);
            @(negedge clock_i);
            n = 0;
            while (spin_active_o === 1'b1 && n < 25000) begin
                n++;
                @(negedge clock_i);
            end
            check("spin length", n >= SU_MS[i] - 1 && n <= SU_MS[i] + 1, 1'b1);
        end
        wr(8'hD0, 8'h00);
        wr(8'hCA, 8'h20);
        wr(8'hD0, 8'h03);
        repeat (3) @(negedge clock_i);
        check("no spin, duty zero", spin_active_o, 1'b0);
        wr(8'hD0, 8'h00);
        wr(8'hCA, 8'h05);
        wr(8'hD0, 8'h03);
        repeat (3) @(negedge clock_i);
        check("no spin, code zero", spin_active_o, 1'b0);
        wr(8'hD0, 8'h00);
        wr(8'hCA, 8'hF5);
        wr(8'hD0, 8'h03);
        repeat (20) @(negedge clock_i);
        check("spin running", spin_active_o, 1'b1);
        wr(8'hD0, 8'h00);
        repeat (3) @(negedge clock_i);
        check("spin aborted", spin_active_o, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
